// File: qbus_dma_regs.vh
// Purpose : shared constants for the host bus DMA and reset interface
// Assumes : 50 MHz system clock
// Notes   : no registers with offsets; all control bits are plain ports
`ifndef QBUS_DMA_REGS_VH
`define QBUS_DMA_REGS_VH

// ----------------------------------------------------------------
// clock and reset timing
// ----------------------------------------------------------------
`define CLK_MHZ          50
`define ARB_PULSE_NS     2000
`define ARB_PULSE_CYC    ((`ARB_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define LOCAL_PULSE_MS   150
`define LOCAL_PULSE_CYC  (`LOCAL_PULSE_MS * `CLK_MHZ * 1000)

// ----------------------------------------------------------------
// widths and block geometry
// ----------------------------------------------------------------
`define QADDR_W          21
`define BADDR_W          16
`define BLOCK_WORDS      16
`define BLOCK_MASK       4'hF

`endif

// File: addr_counter.v
// Purpose : loadable incrementing address counter
// Assumes : load wins over increment
// Notes   : used once per address path so paths never share state
`timescale 1ns/1ps

module addr_counter #(
    parameter W = 16
) (
    // clock and reset
    input  wire         sys_clk,
    input  wire         rst,
    // control
    input  wire         clr,
    input  wire         load,
    input  wire [W-1:0] load_val,
    input  wire         inc,
    // count
    output reg  [W-1:0] cnt_reg
);

    // clear first, then load ahead of increment, so a new job never sees a stale increment
    always @(posedge sys_clk or posedge rst) begin
        if (rst)
            cnt_reg <= {W{1'b0}};
        else if (clr)
            cnt_reg <= {W{1'b0}};
        else if (load)
            cnt_reg <= load_val;
        else if (inc)
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end

endmodule // addr_counter

// File: pulse_timer.v
// Purpose : fixed length reset pulse generator
// Assumes : start is a one cycle pulse
// Notes   : a new start restarts the full length
`timescale 1ns/1ps

module pulse_timer #(
    parameter CW  = 8,
    parameter LEN = 100
) (
    // clock and reset
    input  wire sys_clk,
    input  wire rst,
    // trigger
    input  wire start,
    // pulse
    output reg  busy_reg
);

    reg [CW-1:0] cnt_reg;

    // count down; busy stays high for exactly LEN cycles
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= {CW{1'b0}};
            busy_reg <= 1'b0;
        end else if (start) begin
            cnt_reg  <= LEN[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            busy_reg <= 1'b1;
        end else if (cnt_reg != {CW{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
        end else begin
            busy_reg <= 1'b0;
        end
    end

endmodule // pulse_timer

// File: qbus_dma_reset_interface.v
// Purpose : host bus side interface: resets, reboot, data and control DMA
// Assumes : all inputs synchronous to sys_clk; bus lines are active high here
// Notes   : bus lines active high inside; pin inverters sit outside
`timescale 1ns/1ps
`include "qbus_dma_regs.vh"

module qbus_dma_reset_interface #(
    parameter LOCAL_RST_CYC = `LOCAL_PULSE_CYC,
    parameter AW            = `QADDR_W,
    parameter BW            = `BADDR_W
) (
    // clock and reset
    input  wire          sys_clk,
    input  wire          rst,
    // host bus power and init
    input  wire          bus_power_ok_status,
    input  wire          bus_binit,
    output reg           bus_power_ok_status_out_reg,
    // host bus mastership
    output reg           dmr_reg,
    input  wire          dmg_in,
    output reg           dmg_out_reg,
    output reg           sack_reg,
    // host bus cycle
    output reg           sync_reg,
    output reg           din_reg,
    output reg           dout_reg,
    output reg           block_reg,
    input  wire          rply_in,
    input  wire [AW:0]   dal_in,
    output reg  [AW:0]   dal_out_reg,
    output reg           dal_oe_reg,
    // host slave access
    input  wire          slave_sel,
    input  wire          slave_write,
    input  wire [15:0]   slave_wdata,
    output reg  [15:0]   slave_rdata_reg,
    output reg           slave_rply_reg,
    output reg           slave_wr_pulse_reg,
    // local control bits
    input  wire          csr_sw_reset,
    input  wire          reboot_bit,
    // data DMA job
    input  wire          data_go,
    input  wire          data_to_bp,
    input  wire [AW-1:0] data_qaddr,
    input  wire [BW-1:0] data_baddr,
    input  wire [15:0]   data_words,
    output reg           data_busy_reg,
    output reg           data_done_reg,
    // control DMA job
    input  wire          ctl_go,
    input  wire          ctl_write,
    input  wire          ctl_byte,
    input  wire [AW-1:0] ctl_qaddr,
    input  wire [15:0]   ctl_wdata,
    output reg  [15:0]   path_latch_reg,
    output reg           ctl_busy_reg,
    output reg           ctl_done_reg,
    // backport bus
    output reg           bp_req_reg,
    input  wire          bp_gnt,
    input  wire          bp_ack,
    input  wire [15:0]   bp_din,
    output reg  [15:0]   backport_addr_data_lines_reg,
    output reg           bp_oe_reg,
    output reg           bp_we_reg,
    // reset outputs
    output wire          arb_rst,
    output wire          local_rst,
    output wire          backport_rst,
    output reg           ctl_in_reset_reg,
    // reset cause
    output reg           power_ok_status,
    output reg           internal_host_init,
    output reg           reboot_request
);

    // ----------------------------------------------------------------
    // state codes
    // ----------------------------------------------------------------
    localparam [2:0] QI = 3'd0, QREQ = 3'd1, QADR = 3'd2, QSYN = 3'd3,
                     QDAT = 3'd4, QGAP = 3'd5, QREL = 3'd6;
    localparam [1:0] BI = 2'd0, BREQ = 2'd1, BADR = 2'd2, BDAT = 2'd3;

    reg  [2:0]    q_state_reg;
    reg  [1:0]    b_state_reg;
    reg           q_is_ctl_reg;
    reg           ctl_pend_reg;
    reg           ctl_wr_reg;
    reg           ctl_byte_reg;
    reg           dir_bp_reg;
    reg  [15:0]   q_left_reg;
    reg  [15:0]   b_left_reg;
    reg           hinit_d_reg;
    reg           sw_d_reg;
    reg  [15:0]   buf_mem [0:1];
    reg           wptr_reg;
    reg           rptr_reg;
    reg  [1:0]    cnt_reg;
    wire [AW-1:0] dq_addr;
    wire [AW-1:0] cq_addr;
    wire [BW-1:0] b_addr;

    // ----------------------------------------------------------------
    // reset detection and sequencing
    // ----------------------------------------------------------------
    wire ctl_hold  = ~power_ok_status & internal_host_init;
    wire hinit_fall = hinit_d_reg & ~internal_host_init;
    wire sw_fall   = sw_d_reg & ~csr_sw_reset;

    // sample power, init and reboot levels; init edge compares registered copies, software reset edge compares its copy with the live input
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            power_ok_status    <= 1'b0;
            internal_host_init <= 1'b0;
            reboot_request     <= 1'b0;
            hinit_d_reg        <= 1'b0;
            sw_d_reg           <= 1'b0;
            bus_power_ok_status_out_reg   <= 1'b0;
            ctl_in_reset_reg   <= 1'b0;
            dmg_out_reg        <= 1'b0;
        end else begin
            power_ok_status    <= bus_power_ok_status;
            internal_host_init <= bus_binit;
            reboot_request     <= reboot_bit;
            hinit_d_reg        <= internal_host_init;
            sw_d_reg           <= csr_sw_reset;
            bus_power_ok_status_out_reg   <= ~reboot_bit;
            ctl_in_reset_reg   <= ctl_hold;
            dmg_out_reg        <= dmg_in & ~dmr_reg & ~sack_reg;
        end
    end

    // arbiter reset pulse on init fall
    pulse_timer #(.CW(8), .LEN(`ARB_PULSE_CYC)) u_arb_tmr (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (hinit_fall),
        .busy_reg (arb_rst)
    );

    // long hold for local cpu and network controller
    pulse_timer #(.CW(24), .LEN(LOCAL_RST_CYC)) u_local_tmr (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (hinit_fall),
        .busy_reg (local_rst)
    );

    // backport reset on either falling edge
    pulse_timer #(.CW(8), .LEN(`ARB_PULSE_CYC)) u_bp_tmr (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (hinit_fall | sw_fall),
        .busy_reg (backport_rst)
    );

    // ----------------------------------------------------------------
    // address counters, one per path so a preempted job keeps its place
    // ----------------------------------------------------------------
    wire q_take   = (q_state_reg == QDAT) & rply_in;
    wire dq_inc   = q_take & ~q_is_ctl_reg;
    wire b_take   = (b_state_reg == BDAT) & bp_ack;
    wire job_load = data_go & ~data_busy_reg;
    wire ctl_load = ctl_go & ~ctl_pend_reg;

    addr_counter #(.W(AW)) u_dq_cnt (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clr      (ctl_hold),
        .load     (job_load),
        .load_val (data_qaddr),
        .inc      (dq_inc),
        .cnt_reg  (dq_addr)
    );

    addr_counter #(.W(AW)) u_cq_cnt (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clr      (ctl_hold),
        .load     (ctl_load),
        .load_val (ctl_qaddr),
        .inc      (1'b0),
        .cnt_reg  (cq_addr)
    );

    addr_counter #(.W(BW)) u_b_cnt (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clr      (ctl_hold),
        .load     (job_load),
        .load_val (data_baddr),
        .inc      (b_take),
        .cnt_reg  (b_addr)
    );

    // ----------------------------------------------------------------
    // two word buffer between host bus and backport
    // ----------------------------------------------------------------
    wire        push   = dir_bp_reg ? dq_inc : b_take;
    wire        pop    = dir_bp_reg ? b_take : dq_inc;
    wire [15:0] push_d = dir_bp_reg ? dal_in[15:0] : bp_din;
    wire        q_rdy  = dir_bp_reg ? (cnt_reg != 2'd2) : (cnt_reg != 2'd0);
    wire        b_rdy  = dir_bp_reg ? (cnt_reg != 2'd0) : (cnt_reg != 2'd2);
    // next word address crossing into a new 16 word block
    wire        q_bound = ((dq_addr[3:0] & `BLOCK_MASK) == 4'h0);

    // both sides may move in one cycle, which keeps the pipe full
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg  <= 2'd0;
        end else if (ctl_hold | job_load) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg  <= 2'd0;
        end else begin
            if (push) begin
                buf_mem[wptr_reg] <= push_d;
                wptr_reg          <= ~wptr_reg;
            end
            if (pop)
                rptr_reg <= ~rptr_reg;
            if (push & ~pop)
                cnt_reg <= cnt_reg + 2'd1;
            else if (pop & ~push)
                cnt_reg <= cnt_reg - 2'd1;
        end
    end

    // ----------------------------------------------------------------
    // job bookkeeping and slave path
    // ----------------------------------------------------------------
    wire ctl_owns = q_is_ctl_reg & sack_reg;
    wire slave_ok = slave_sel & ~ctl_owns;

    // slave held off only while control DMA owns the shared latch
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slave_rply_reg     <= 1'b0;
            slave_wr_pulse_reg <= 1'b0;
            slave_rdata_reg    <= 16'h0000;
        end else begin
            slave_wr_pulse_reg <= 1'b0;
            if (~slave_sel) begin
                slave_rply_reg <= 1'b0;
            end else if (slave_ok & ~slave_rply_reg) begin
                slave_rply_reg     <= 1'b1;
                slave_wr_pulse_reg <= slave_write;
                slave_rdata_reg    <= {13'h0000, reboot_request,
                                       internal_host_init, power_ok_status};
            end
        end
    end

    // job counts and completion flags
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_busy_reg <= 1'b0;
            data_done_reg <= 1'b0;
            dir_bp_reg    <= 1'b0;
            q_left_reg    <= 16'h0000;
            b_left_reg    <= 16'h0000;
        end else if (ctl_hold) begin
            data_busy_reg <= 1'b0;
            data_done_reg <= 1'b0;
            q_left_reg    <= 16'h0000;
            b_left_reg    <= 16'h0000;
        end else begin
            data_done_reg <= 1'b0;
            if (job_load) begin
                data_busy_reg <= (data_words != 16'h0000);
                dir_bp_reg    <= data_to_bp;
                q_left_reg    <= data_words;
                b_left_reg    <= data_words;
            end else begin
                if (dq_inc)
                    q_left_reg <= q_left_reg - 16'h0001;
                if (b_take)
                    b_left_reg <= b_left_reg - 16'h0001;
                if (data_busy_reg & (q_left_reg == 16'h0000) &
                    (b_left_reg == 16'h0000) & (q_state_reg == QI)) begin
                    data_busy_reg <= 1'b0;
                    data_done_reg <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // host bus master sequencer
    // ----------------------------------------------------------------
    wire q_wr = q_is_ctl_reg ? ctl_wr_reg : ~dir_bp_reg;
    wire data_more = data_busy_reg & (q_left_reg != 16'h0000) & q_rdy;

    // control always served before data; data restarts from its counter
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_state_reg    <= QI;
            q_is_ctl_reg   <= 1'b0;
            ctl_pend_reg   <= 1'b0;
            ctl_wr_reg     <= 1'b0;
            ctl_byte_reg   <= 1'b0;
            ctl_busy_reg   <= 1'b0;
            ctl_done_reg   <= 1'b0;
            path_latch_reg <= 16'h0000;
            dmr_reg        <= 1'b0;
            sack_reg       <= 1'b0;
            sync_reg       <= 1'b0;
            din_reg        <= 1'b0;
            dout_reg       <= 1'b0;
            block_reg      <= 1'b0;
            dal_out_reg    <= {(AW+1){1'b0}};
            dal_oe_reg     <= 1'b0;
        end else if (ctl_hold) begin
            q_state_reg  <= QI;
            ctl_pend_reg <= 1'b0;
            ctl_busy_reg <= 1'b0;
            ctl_done_reg <= 1'b0;
            dmr_reg      <= 1'b0;
            sack_reg     <= 1'b0;
            sync_reg     <= 1'b0;
            din_reg      <= 1'b0;
            dout_reg     <= 1'b0;
            block_reg    <= 1'b0;
            dal_oe_reg   <= 1'b0;
        end else begin
            ctl_done_reg <= 1'b0;
            if (ctl_load) begin
                ctl_pend_reg <= 1'b1;
                ctl_busy_reg <= 1'b1;
                ctl_wr_reg   <= ctl_write;
                ctl_byte_reg <= ctl_byte;
            end
            if (slave_ok & slave_write & ~slave_rply_reg)
                path_latch_reg <= slave_wdata;
            case (q_state_reg)
                QI: begin
                    if (ctl_pend_reg & ~slave_sel) begin
                        q_is_ctl_reg   <= 1'b1;
                        dmr_reg        <= 1'b1;
                        q_state_reg    <= QREQ;
                    end else if (~ctl_pend_reg & data_more) begin
                        q_is_ctl_reg <= 1'b0;
                        dmr_reg      <= 1'b1;
                        q_state_reg  <= QREQ;
                    end
                end
                QREQ: begin
                    if (dmg_in) begin
                        // latch taken only at grant: slave may use it while we wait
                        if (q_is_ctl_reg)
                            path_latch_reg <= ctl_wdata;
                        dmr_reg     <= 1'b0;
                        sack_reg    <= 1'b1;
                        q_state_reg <= QADR;
                    end
                end
                QADR: begin
                    // word address, bit zero held low
                    dal_out_reg <= {q_is_ctl_reg ? cq_addr : dq_addr, 1'b0};
                    dal_oe_reg  <= 1'b1;
                    block_reg   <= ~q_is_ctl_reg;
                    q_state_reg <= QSYN;
                end
                QSYN: begin
                    sync_reg    <= 1'b1;
                    dal_out_reg <= {{(AW-15){1'b0}},
                                    q_is_ctl_reg ? path_latch_reg : buf_mem[rptr_reg]};
                    dal_oe_reg  <= q_wr;
                    dout_reg    <= q_wr;
                    din_reg     <= ~q_wr;
                    q_state_reg <= QDAT;
                end
                QDAT: begin
                    if (rply_in) begin
                        din_reg  <= 1'b0;
                        dout_reg <= 1'b0;
                        if (q_is_ctl_reg & ~ctl_wr_reg)
                            path_latch_reg <= ctl_byte_reg ? {8'h00, dal_in[7:0]} : dal_in[15:0];
                        q_state_reg <= QGAP;
                    end
                end
                QGAP: begin
                    // wait for reply to drop before next word or release
                    if (~rply_in) begin
                        if (~q_is_ctl_reg & data_more & ~q_bound & ~ctl_pend_reg) begin
                            dal_out_reg <= {{(AW-15){1'b0}}, buf_mem[rptr_reg]};
                            dal_oe_reg  <= q_wr;
                            dout_reg    <= q_wr;
                            din_reg     <= ~q_wr;
                            q_state_reg <= QDAT;
                        end else begin
                            if (q_is_ctl_reg) begin
                                ctl_pend_reg <= 1'b0;
                                ctl_busy_reg <= 1'b0;
                                ctl_done_reg <= 1'b1;
                            end
                            q_state_reg <= QREL;
                        end
                    end
                end
                QREL: begin
                    sync_reg    <= 1'b0;
                    sack_reg    <= 1'b0;
                    dal_oe_reg  <= 1'b0;
                    block_reg   <= 1'b0;
                    q_state_reg <= QI;
                end
                default: q_state_reg <= QI;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // backport master sequencer
    // ----------------------------------------------------------------
    // address goes out with bit 0 on the top line, then bits 15:1
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            b_state_reg                  <= BI;
            bp_req_reg                   <= 1'b0;
            bp_oe_reg                    <= 1'b0;
            bp_we_reg                    <= 1'b0;
            backport_addr_data_lines_reg <= 16'h0000;
        end else if (ctl_hold | backport_rst) begin
            b_state_reg <= BI;
            bp_req_reg  <= 1'b0;
            bp_oe_reg   <= 1'b0;
            bp_we_reg   <= 1'b0;
        end else begin
            case (b_state_reg)
                BI: begin
                    if (data_busy_reg & (b_left_reg != 16'h0000) & b_rdy) begin
                        bp_req_reg  <= 1'b1;
                        b_state_reg <= BREQ;
                    end
                end
                BREQ: begin
                    if (bp_gnt) begin
                        backport_addr_data_lines_reg <= {b_addr[0], b_addr[BW-1:1]};
                        bp_oe_reg   <= 1'b1;
                        b_state_reg <= BADR;
                    end
                end
                BADR: begin
                    backport_addr_data_lines_reg <= buf_mem[rptr_reg];
                    bp_oe_reg   <= dir_bp_reg;
                    bp_we_reg   <= dir_bp_reg;
                    b_state_reg <= BDAT;
                end
                BDAT: begin
                    if (bp_ack) begin
                        bp_req_reg  <= 1'b0;
                        bp_oe_reg   <= 1'b0;
                        bp_we_reg   <= 1'b0;
                        b_state_reg <= BI;
                    end
                end
                default: b_state_reg <= BI;
            endcase
        end
    end

endmodule // qbus_dma_reset_interface

// File: qdma_assertions.sv
// Purpose: port checker for the host bus dma and reset interface
// Assumes: one clock domain, rst active high
// Notes: bound to the top module at the foot
`timescale 1ns/1ps
module qdma_chk (
    // watched ports
    input logic sys_clk, rst, bus_power_ok_status, bus_binit, reboot_bit, csr_sw_reset, dmg_in, slave_sel, dal_oe_reg,
    input logic bus_power_ok_status_out_reg, ctl_in_reset_reg, internal_host_init, arb_rst, backport_rst, local_rst,
    input logic dmr_reg, sack_reg, dmg_out_reg, sync_reg, din_reg, dout_reg, slave_rply_reg,
    input logic [21:0] dal_out_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_reboot_drops_ok: assert property (reboot_bit |=> !bus_power_ok_status_out_reg) else $error("power_ok_status out high");
    a_init_holds_ctl: assert property (!bus_power_ok_status && bus_binit |-> ##[1:2] ctl_in_reset_reg) else $error("no hold");
    a_init_fall_pulses: assert property ($fell(internal_host_init) |=> arb_rst && local_rst && backport_rst)
        else $error("reset pulses late");
    a_arb_width: assert property ($fell(arb_rst) |-> $past(arb_rst, 100)) else $error("arb pulse short");
    a_sw_reset: assert property ($fell(csr_sw_reset) |-> ##[1:3] backport_rst) else $error("no sw reset");
    a_grant_pass: assert property (dmg_in && !dmr_reg && !sack_reg |=> dmg_out_reg) else $error("grant lost");
    a_grant_kept: assert property (dmr_reg || sack_reg |=> !dmg_out_reg) else $error("grant leaked");
    a_addr_even: assert property ($rose(sync_reg) |-> $past(dal_oe_reg) && !$past(dal_out_reg[0]))
        else $error("odd address");
    a_strobe_owned: assert property (din_reg || dout_reg |-> sync_reg && sack_reg) else $error("strobe unowned");
    a_slave_reply: assert property (slave_sel && !sack_reg && !slave_rply_reg |=> slave_rply_reg)
        else $error("no slave reply");
    c_init_fall: cover property ($fell(internal_host_init));
    c_reboot: cover property (reboot_bit && !bus_power_ok_status_out_reg);
    c_bus_cycle: cover property ($rose(sync_reg));
endmodule // qdma_chk
bind qbus_dma_reset_interface qdma_chk u_chk (.*);

// File: qbus_host_model.sv
// Purpose: far side model, host bus slave and arbiter plus backport
// Assumes: lag sets the host reply delay
// Notes: released lines invert each cycle so stale data never looks valid
`timescale 1ns/1ps
module qbus_host_model (
    // clock, knobs and strobes
    input  logic        sys_clk, rst, ext_grant, dmr_reg, din_reg, dout_reg, bp_req_reg,
    input  logic [3:0]  lag,
    // answers
    output logic        dmg_in, rply_in, bp_gnt, bp_ack,
    output logic [21:0] dal_in,
    output logic [15:0] bp_din
);
    logic [3:0] w;
    logic [2:0] bc;
    // grant the requester, reply after lag, backport ack three cycles into a grant
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {dmg_in, rply_in, bp_gnt, bp_ack, w, bc, dal_in, bp_din} <= '0;
        end else begin
            dmg_in <= dmr_reg | ext_grant;
            w <= (din_reg | dout_reg) ? w + 4'h1 : 4'h0;
            rply_in <= (din_reg | dout_reg) && w >= lag;
            dal_in <= din_reg ? 22'h00C35A : ~dal_in;
            bp_gnt <= bp_req_reg;
            bc <= bp_gnt ? bc + 3'h1 : 3'h0;
            bp_ack <= bp_gnt && bp_req_reg && bc == 3'h2;
            bp_din <= bp_gnt ? 16'h3C96 : ~bp_din;
        end
    end
endmodule // qbus_host_model

// File: test_qbus_dma_reset_interface.sv
// Purpose: bench for the host bus dma and reset interface
// Assumes: local reset shortened to 200 cycles
// Notes: pulse widths and bus events counted on the clock
`timescale 1ns/1ps
module test_qbus_dma_reset_interface;
    logic sys_clk = 0, rst = 1, bus_power_ok_status = 1, bus_binit = 0, slave_sel = 0, slave_write = 0, csr_sw_reset = 0;
    logic reboot_bit = 0, data_go = 0, data_to_bp = 1, ctl_go = 0, ctl_write = 0, ctl_byte = 0, ext_grant = 0;
    logic [3:0] lag = 4'h3;
    logic [20:0] data_qaddr = 21'h00000E, ctl_qaddr = 21'h000100;
    logic [15:0] data_baddr = 16'h0003, data_words = 16'h0014, slave_wdata = 16'h0000, ctl_wdata = 16'h1234, fa;
    wire dmg_in, rply_in, bp_gnt, bp_ack, bus_power_ok_status_out_reg, dmr_reg, dmg_out_reg, sack_reg, sync_reg, din_reg;
    wire dout_reg, block_reg, dal_oe_reg, slave_rply_reg, slave_wr_pulse_reg, data_busy_reg, data_done_reg;
    wire ctl_busy_reg, ctl_done_reg, bp_req_reg, bp_oe_reg, bp_we_reg, arb_rst, local_rst, backport_rst;
    wire ctl_in_reset_reg, power_ok_status, internal_host_init, reboot_request;
    wire [21:0] dal_in, dal_out_reg;
    wire [15:0] bp_din, slave_rdata_reg, path_latch_reg, backport_addr_data_lines_reg;
    int n_fail = 0, checks = 0, cyc = 0, na, nl, nb, ns, nk, nbk;
    qbus_dma_reset_interface #(.LOCAL_RST_CYC(200)) uut (.*);
    qbus_host_model hm (.*);
    always #10 sys_clk = ~sys_clk;
    // event counters; the ceiling stops a hung run
    always @(posedge sys_clk) begin
        na += arb_rst; nl += local_rst; nb += backport_rst; ns += $rose(sync_reg); nk += bp_ack;
        nbk += block_reg & $rose(sync_reg);
        if ($rose(bp_oe_reg) && nk == 0) fa = backport_addr_data_lines_reg;
        if (++cyc == 10000) begin n_fail++; wrap_up; end
    end
    task chk(input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin n_fail++; $display("BAD %0t got %h want %h", $time, seen, exp); end
    endtask
    task wrap_up;
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick(input int n); repeat (n) @(negedge sys_clk); endtask
    task rd(input logic [2:0] e);
        slave_sel = 1; tick(2);
        chk(slave_rdata_reg, {13'h0000, e});
        chk(slave_rply_reg, 16'h0001);
        slave_sel = 0; tick(2);
    endtask
    task ctl(input logic b, s, input logic [15:0] e);
        ctl_byte = b; slave_sel = s; ctl_go = 1; tick(1); ctl_go = 0;
        chk(ctl_busy_reg, 16'h0001);
        tick(1); chk(16'(dmr_reg & s), 16'h0000);
        chk(slave_rply_reg, 16'(s));
        slave_sel = 0;
        for (int i = 0; i < 300 && ctl_done_reg !== 1'b1; i++) tick(1);
        chk(ctl_done_reg, 16'h0001);
        tick(1); chk(path_latch_reg, e);
    endtask
    // reset codes, pulses, reboot, grant chain, control and data dma
    initial begin
        tick(8); rst = 0; tick(2); rd(3'h1);
        bus_power_ok_status = 0; bus_binit = 1; tick(4);
        chk(ctl_in_reset_reg, 16'h0001);
        rd(3'h2);
        na = 0; nl = 0; nb = 0; bus_binit = 0; tick(250);
        chk(16'(na), 16'h0064);
        chk(16'(nl), 16'h00C8);
        chk(16'(nb), 16'h0064);
        rd(3'h0); bus_power_ok_status = 1; reboot_bit = 1; tick(2);
        chk(bus_power_ok_status_out_reg, 16'h0000);
        rd(3'h5); reboot_bit = 0; csr_sw_reset = 1; tick(2); nb = 0; csr_sw_reset = 0; tick(110);
        chk(16'(nb), 16'h0064);
        ext_grant = 1; tick(2);
        chk(dmg_out_reg, 16'h0001);
        ext_grant = 0; tick(2); $display("reset tests done");
        ctl(0, 1, 16'hC35A); ctl(1, 0, 16'h005A);
        ctl_write = 1; ctl(0, 0, 16'h1234); ctl_write = 0; $display("control test done");
        ns = 0; nk = 0; nbk = 0; lag = 4'h0; data_go = 1; tick(1); data_go = 0; tick(30); ctl(0, 0, 16'hC35A);
        for (int i = 0; i < 3000 && data_done_reg !== 1'b1; i++) tick(1);
        chk(data_done_reg, 16'h0001);
        chk(16'(nbk), 16'(ns - 1));
        chk(16'(nk), 16'h0014);
        chk(fa, 16'h8001);
        chk(16'(ns >= 5), 16'h0001);
        $display("data test done"); wrap_up;
    end
endmodule // test_qbus_dma_reset_interface
